// File: bench/async_receiver_address_detect_tb.sv
`timescale 1ns/1ps
module async_receiver_address_detect_tb;
  localparam logic [7:0] ST = addr_rx_pkg::ADDR_RECEIVE_STATUS_CONTROL;
  localparam logic [7:0] DT = addr_rx_pkg::ADDR_RECEIVE_DATA;
  localparam logic [7:0] IE = addr_rx_pkg::ADDR_IRQ_ENABLE;
  localparam logic [7:0] IFL = addr_rx_pkg::ADDR_IRQ_FLAG;
  logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_IRQ;
  logic [7:0] PADDR, seed;
  logic [31:0] PWDATA, PRDATA;
  logic line, busy, go, glitch, nine, stop_bit;
  logic [8:0] data, a, b;
  logic [32:0] expq[$];
  int fails, num_checks;

  addr_rx i_addr_rx (.CLOCK(CLOCK), .RST_N(RST_N), .RX_IN(line), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_IRQ(RX_IRQ));
  serial_tx_model #(.BIT_CLKS(64)) i_serial_tx_model (.CLOCK(CLOCK), .go(go),
    .glitch(glitch), .nine(nine), .stop_bit(stop_bit), .data(data), .line(line), .busy(busy));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Idle edge first, so back-to-back calls never assign PSEL twice at once
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= {24'h00_0000, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      fails++;
      final_report();
    end
  endtask : apb

  task automatic rd(input logic [7:0] ad, input logic [7:0] e, input logic err);
    expq.push_back({err, 24'h00_0000, e});
    apb(1'b0, ad, 8'h00);
  endtask : rd

  task automatic send(input logic [8:0] d, input logic st, input logic gl);
    int n;
    n = 0;
    @(posedge CLOCK);
    data <= d;
    stop_bit <= st;
    glitch <= gl;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (busy === 1'b1 && n < 2000);
    if (busy !== 1'b0) begin
      fails++;
      final_report();
    end
    repeat (4) @(posedge CLOCK);
  endtask : send

  // Read results are judged here, in issue order
  always @(posedge CLOCK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && PWRITE === 1'b0) begin
      check({PSLVERR, PRDATA}, expq.pop_front());
    end
  end

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    go = 1'b0;
    glitch = 1'b0;
    nine = 1'b1;
    stop_bit = 1'b1;
    data = 9'h000;
    seed = 8'h28;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge CLOCK);
    RST_N <= 1'b1;
    rd(ST, 8'h00, 1'b0);
    rd(8'h08, 8'h02, 1'b0);
    rd(8'h20, 8'h00, 1'b1);
    $display("test reset done");
    // Tick = divisor + 1 = 4 clocks, bit = 64 clocks
    apb(1'b1, 8'h10, 8'h03);
    apb(1'b1, 8'h14, 8'h00);
    apb(1'b1, 8'h0C, 8'h08);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, IE, 8'h01);
    apb(1'b1, ST, 8'hD0);
    seed = lfsr(seed);
    a = {1'b1, seed};
    seed = lfsr(seed);
    b = {1'b0, seed};
    send(a, 1'b1, 1'b0);
    send(b, 1'b1, 1'b0);
    check({32'h0000_0000, RX_IRQ}, 33'h1);
    rd(IFL, 8'h01, 1'b0);
    rd(ST, 8'hD1, 1'b0);
    rd(DT, a[7:0], 1'b0);
    rd(ST, 8'hD0, 1'b0);
    rd(DT, b[7:0], 1'b0);
    repeat (3) @(posedge CLOCK);
    check({32'h0000_0000, RX_IRQ}, 33'h0);
    $display("test pass all done");
    apb(1'b1, ST, 8'hD8);
    seed = lfsr(seed);
    send(9'h133, 1'b1, 1'b0);
    send({1'b1, seed}, 1'b1, 1'b0);
    send(9'h044, 1'b1, 1'b0);
    send(9'h0EE, 1'b1, 1'b0);
    rd(ST, 8'hD9, 1'b0);
    rd(DT, 8'h33, 1'b0);
    rd(ST, 8'hD9, 1'b0);
    rd(DT, seed, 1'b0);
    rd(IFL, 8'h00, 1'b0);
    apb(1'b1, ST, 8'hD0);
    send(9'h077, 1'b1, 1'b0);
    rd(ST, 8'hD0, 1'b0);
    rd(DT, 8'h77, 1'b0);
    apb(1'b1, ST, 8'hD8);
    send(9'h055, 1'b1, 1'b0);
    rd(IFL, 8'h00, 1'b0);
    $display("test filter done");
    apb(1'b1, ST, 8'hD0);
    apb(1'b1, IE, 8'h00);
    send(a, 1'b1, 1'b0);
    send(b, 1'b1, 1'b0);
    send(9'h1FF, 1'b1, 1'b0);
    check({32'h0000_0000, RX_IRQ}, 33'h0);
    rd(ST, {7'h69, a[8]}, 1'b0);
    rd(DT, a[7:0], 1'b0);
    rd(ST, {7'h69, b[8]}, 1'b0);
    rd(DT, b[7:0], 1'b0);
    apb(1'b1, ST, 8'hC0);
    rd(ST, 8'hC0, 1'b0);
    rd(IFL, 8'h00, 1'b0);
    apb(1'b1, IE, 8'h01);
    $display("test overrun done");
    apb(1'b1, ST, 8'h90);
    nine <= 1'b0;
    send(9'h0C3, 1'b0, 1'b0);
    send(9'h000, 1'b1, 1'b1);
    send(9'h13C, 1'b1, 1'b0);
    rd(ST, 8'h94, 1'b0);
    rd(DT, 8'hC3, 1'b0);
    rd(ST, 8'h90, 1'b0);
    rd(DT, 8'h3C, 1'b0);
    rd(IFL, 8'h00, 1'b0);
    $display("test framing done");
    final_report();
  end
endmodule : async_receiver_address_detect_tb

// File: bench/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int BIT_CLKS = 64
) (
  input wire logic CLOCK,
  input wire logic go,
  input wire logic glitch,
  input wire logic nine,
  input wire logic stop_bit,
  input wire logic [8:0] data,
  output logic line,
  output logic busy
);
  logic [11:0] frame;
  int nbits;
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge CLOCK);
      if (go) begin
        busy <= 1'b1;
        // Start low, data LSB first, ninth bit last when nine is set, then stop
        frame = nine ? {1'b1, stop_bit, data, 1'b0} : {2'b11, stop_bit, data[7:0], 1'b0};
        nbits = glitch ? 1 : (nine ? 11 : 10);
        for (int i = 0; i < nbits; i++) begin
          line <= frame[i];
          // Glitch is far shorter than half a bit
          repeat (glitch ? BIT_CLKS / 8 : BIT_CLKS) @(posedge CLOCK);
        end
        line <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : serial_tx_model

// File: verilog/addr_rx.sv
// Overview of operation
// - Address-detect bit set enters filtering mode
// - Filtering assumes nine-bit reception is selected
// - Filtering keeps only ninth-bit-set characters
// - Filter off passes every character
// - Ready flag on store; irq when enabled
// - Filtered characters read ninth bit one
// - Needs port enable and async mode
// - Nine-bit select shifts nine data bits
// - Reception starts after continuous enable set
// - Clearing continuous enable clears overrun
// - Baud from 16-bit divisor and mode bits
// - Two-entry FIFO; third char overruns, blocks
// - Start bit verified at half bit
// - Stop zero sets per-character framing error
// - Sixteen-times sampling with majority vote
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module addr_rx #(
  parameter int DIV_WIDTH = 16
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic RX_IN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic RX_IRQ
);
  if (DIV_WIDTH != 16) begin : g_width_check
    $error("addr_rx: divisor must be 16 bits");
  end

  logic [7:0] rcv_ctrl_r;
  logic [7:0] xmt_ctrl_r;
  logic [7:0] baud_ctrl_r;
  logic [DIV_WIDTH-1:0] divisor_r;
  logic irq_en_r;
  logic overrun_r;
  addr_rx_pkg::rx_cfg_t cfg;
  addr_rx_pkg::rx_char_t fifo_r [addr_rx_pkg::FIFO_DEPTH];
  logic [1:0] count_r;
  logic rd_ptr_r;
  logic wr_ptr_r;

  assign cfg.serial_port_en = rcv_ctrl_r[addr_rx_pkg::SERIAL_PORT_EN_BIT];
  assign cfg.nine_bit_receive_sel = rcv_ctrl_r[addr_rx_pkg::NINE_BIT_RECEIVE_SEL_BIT];
  assign cfg.continuous_receive_en = rcv_ctrl_r[addr_rx_pkg::CONTINUOUS_RECEIVE_EN_BIT];
  assign cfg.addr_detect_en = rcv_ctrl_r[addr_rx_pkg::ADDR_DETECT_EN_BIT];
  assign cfg.sync_mode = xmt_ctrl_r[addr_rx_pkg::SYNC_MODE_BIT];
  assign cfg.high_speed_sel = xmt_ctrl_r[addr_rx_pkg::HIGH_SPEED_SEL_BIT];
  assign cfg.wide_divisor_sel = baud_ctrl_r[addr_rx_pkg::WIDE_DIVISOR_SEL_BIT];

  logic rx_active;
  assign rx_active = cfg.serial_port_en && !cfg.sync_mode
      && cfg.continuous_receive_en;

  // APB: zero wait states; unmapped addresses read zero with PSLVERR
  logic apb_access;
  logic wr_en;
  logic rd_data_pop;
  logic addr_hit;
  assign PREADY = 1'b1;
  assign apb_access = PSEL && PENABLE;
  assign wr_en = apb_access && PWRITE;
  assign rd_data_pop = apb_access && !PWRITE
      && PADDR == addr_rx_pkg::ADDR_RECEIVE_DATA;
  always_comb begin
    addr_hit = 1'b1;
    unique case (PADDR)
      addr_rx_pkg::ADDR_RECEIVE_STATUS_CONTROL, addr_rx_pkg::ADDR_RECEIVE_DATA,
      addr_rx_pkg::ADDR_TRANSMIT_STATUS_CONTROL, addr_rx_pkg::ADDR_BAUD_CONTROL,
      addr_rx_pkg::ADDR_RATE_DIVISOR_LOW, addr_rx_pkg::ADDR_RATE_DIVISOR_HIGH,
      addr_rx_pkg::ADDR_IRQ_ENABLE, addr_rx_pkg::ADDR_IRQ_FLAG: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign PSLVERR = apb_access && !addr_hit;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rcv_ctrl_r <= addr_rx_pkg::RCV_CTRL_RESET;
      xmt_ctrl_r <= addr_rx_pkg::XMT_CTRL_RESET;
      baud_ctrl_r <= addr_rx_pkg::BAUD_CTRL_RESET;
      divisor_r <= addr_rx_pkg::DIVISOR_RESET;
      irq_en_r <= 1'b0;
    end else if (wr_en) begin
      unique case (PADDR)
        addr_rx_pkg::ADDR_RECEIVE_STATUS_CONTROL: begin
          rcv_ctrl_r <= {PWDATA[7:6], 1'b0, PWDATA[4:3], 3'h0};
        end
        addr_rx_pkg::ADDR_TRANSMIT_STATUS_CONTROL: begin
          xmt_ctrl_r <= {3'h0, PWDATA[4], 1'b0, PWDATA[2], 2'h0};
        end
        addr_rx_pkg::ADDR_BAUD_CONTROL: begin
          baud_ctrl_r <= {4'h0, PWDATA[3], 3'h0};
        end
        addr_rx_pkg::ADDR_RATE_DIVISOR_LOW: divisor_r[7:0] <= PWDATA[7:0];
        addr_rx_pkg::ADDR_RATE_DIVISOR_HIGH: divisor_r[15:8] <= PWDATA[7:0];
        addr_rx_pkg::ADDR_IRQ_ENABLE: irq_en_r <= PWDATA[0];
        default: begin
        end
      endcase
    end
  end

  // Baud tick at 16x: divisor count per mode. Low-speed 8-bit mode
  // needs 64 clocks per bit, so four divisor counts per 16x tick.
  logic [15:0] div_cnt_r;
  logic [1:0] pre_cnt_r;
  logic [15:0] div_top;
  logic [1:0] pre_top;
  logic tick;
  always_comb begin
    div_top = cfg.wide_divisor_sel ? divisor_r : {8'h00, divisor_r[7:0]};
    unique case ({cfg.wide_divisor_sel, cfg.high_speed_sel})
      2'b00: pre_top = 2'h3;
      2'b01, 2'b10: pre_top = 2'h0;
      2'b11: pre_top = 2'h0;
    endcase
  end
  // With both selects set the bit rate equals that with the wide-divisor select alone; 16x sampling caps it
  assign tick = div_cnt_r == 16'h0000 && pre_cnt_r == 2'h0;
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !cfg.serial_port_en) begin
      div_cnt_r <= 16'h0000;
      pre_cnt_r <= 2'h0;
    end else if (div_cnt_r != 16'h0000) begin
      div_cnt_r <= div_cnt_r - 16'h0001;
    end else begin
      div_cnt_r <= div_top;
      pre_cnt_r <= (pre_cnt_r == 2'h0) ? pre_top : pre_cnt_r - 2'h1;
    end
  end

  // Receive state machine
  addr_rx_pkg::rx_state_t state_r;
  logic [3:0] tick_cnt_r;
  logic [3:0] bit_cnt_r;
  logic [8:0] receive_shift_reg;
  logic [2:0] vote_r;
  logic rx_prev_r;
  logic maj;
  logic [3:0] data_bits;
  logic char_done;
  logic keep_char;
  logic store;
  assign maj = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2])
      | (vote_r[0] & vote_r[2]);
  assign data_bits = cfg.nine_bit_receive_sel ? 4'h9 : 4'h8;
  // Done once the stop votes are in, so a start edge right after is seen
  localparam logic [3:0] STOP_DONE_TICK = addr_rx_pkg::HALF_BIT_TICKS + 4'h2;
  assign char_done = tick && state_r == addr_rx_pkg::RX_STOP
      && tick_cnt_r == STOP_DONE_TICK;
  // Filter uses the enable present at char_done; eight-bit chars all drop
  assign keep_char = !cfg.addr_detect_en || receive_shift_reg[8];
  assign store = char_done && keep_char && !overrun_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= RX_IN;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N || !rx_active) begin
      state_r <= addr_rx_pkg::RX_IDLE;
      tick_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      receive_shift_reg <= 9'h000;
      vote_r <= 3'h7;
    end else if (overrun_r) begin
      state_r <= addr_rx_pkg::RX_IDLE;
    end else begin
      unique case (state_r)
        addr_rx_pkg::RX_IDLE: begin
          tick_cnt_r <= 4'h0;
          bit_cnt_r <= 4'h0;
          if (rx_prev_r && !RX_IN) state_r <= addr_rx_pkg::RX_START;
        end
        addr_rx_pkg::RX_START: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r == addr_rx_pkg::HALF_BIT_TICKS && RX_IN) begin
              // No error on a glitch, just resume hunting
              tick_cnt_r <= 4'h0;
              state_r <= addr_rx_pkg::RX_IDLE;
            end else if (tick_cnt_r == addr_rx_pkg::LAST_TICK) begin
              // Bit counts restart on bit edges, so votes fall on centres
              state_r <= addr_rx_pkg::RX_DATA;
            end
          end
        end
        addr_rx_pkg::RX_DATA, addr_rx_pkg::RX_STOP: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r >= 4'h6 && tick_cnt_r <= 4'h8) begin
              vote_r <= {vote_r[1:0], RX_IN};
            end
            if (state_r == addr_rx_pkg::RX_STOP) begin
              // Leave at the stop centre, ahead of the next start edge
              if (tick_cnt_r == STOP_DONE_TICK) state_r <= addr_rx_pkg::RX_IDLE;
            end else if (tick_cnt_r == addr_rx_pkg::LAST_TICK) begin
              receive_shift_reg <= cfg.nine_bit_receive_sel
                  ? {maj, receive_shift_reg[8:1]}
                  : {1'b0, maj, receive_shift_reg[7:1]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r + 4'h1 == data_bits) state_r <= addr_rx_pkg::RX_STOP;
            end
          end
        end
      endcase
    end
  end
  // Stop level is the majority of the three stop center votes, valid at char_done
  logic stop_bad;
  assign stop_bad = !maj;

  // A pop in the same cycle frees the slot that a full buffer needs,
  // so a character finishing then is kept rather than lost
  logic push;
  logic pop;
  assign pop = rd_data_pop && count_r != 2'h0;
  assign push = store && (count_r != 2'h2 || pop);

  always_ff @(posedge CLOCK) begin
    if (!RST_N || !cfg.serial_port_en) begin
      count_r <= 2'h0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
    end else begin
      if (push) begin
        fifo_r[wr_ptr_r] <= '{framing_error: stop_bad, data: receive_shift_reg};
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Overrun: a third whole character with both entries full
  // Filtered characters fail keep_char, so they never overrun
  always_ff @(posedge CLOCK) begin
    if (!RST_N || !cfg.continuous_receive_en || !cfg.serial_port_en) begin
      overrun_r <= 1'b0;
    end else if (char_done && keep_char && count_r == 2'h2 && !rd_data_pop) begin
      overrun_r <= 1'b1;
    end
  end

  logic receive_ready_flag;
  addr_rx_pkg::rx_char_t top;
  assign receive_ready_flag = count_r != 2'h0;
  assign top = fifo_r[rd_ptr_r];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      RX_IRQ <= 1'b0;
    end else begin
      RX_IRQ <= receive_ready_flag && irq_en_r;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (PADDR)
      addr_rx_pkg::ADDR_RECEIVE_STATUS_CONTROL: begin
        rd_byte = rcv_ctrl_r;
        rd_byte[addr_rx_pkg::FRAMING_ERROR_BIT] = top.framing_error && receive_ready_flag;
        rd_byte[addr_rx_pkg::OVERRUN_ERROR_BIT] = overrun_r;
        // Like framing, no stale ninth bit once the buffer is empty
        rd_byte[addr_rx_pkg::NINTH_RECEIVE_BIT] = top.data[8] && receive_ready_flag;
      end
      addr_rx_pkg::ADDR_RECEIVE_DATA: rd_byte = top.data[7:0];
      addr_rx_pkg::ADDR_TRANSMIT_STATUS_CONTROL: begin
        rd_byte = xmt_ctrl_r;
        rd_byte[addr_rx_pkg::SHIFT_EMPTY_BIT] = 1'b1;
      end
      addr_rx_pkg::ADDR_BAUD_CONTROL: begin
        rd_byte = baud_ctrl_r;
        rd_byte[addr_rx_pkg::RECEIVE_IDLE_BIT] = state_r == addr_rx_pkg::RX_IDLE;
      end
      addr_rx_pkg::ADDR_RATE_DIVISOR_LOW: rd_byte = divisor_r[7:0];
      addr_rx_pkg::ADDR_RATE_DIVISOR_HIGH: rd_byte = divisor_r[15:8];
      addr_rx_pkg::ADDR_IRQ_ENABLE: rd_byte = {7'h00, irq_en_r};
      addr_rx_pkg::ADDR_IRQ_FLAG: rd_byte = {7'h00, receive_ready_flag};
      default: rd_byte = 8'h00;
    endcase
  end
  assign PRDATA = {24'h00_0000, rd_byte};

  // Checks on the receive path and the buffer
  a_filter_drops_plain: assert property (@(posedge CLOCK) disable iff (!RST_N)
      char_done && cfg.addr_detect_en && !receive_shift_reg[8]
      |=> $stable(wr_ptr_r)) else $error("filtered char stored");
  a_pass_all_chars: assert property (@(posedge CLOCK) disable iff (!RST_N)
      char_done && !cfg.addr_detect_en && !overrun_r && count_r == 2'h0 && !rd_data_pop
      |=> count_r == 2'h1) else $error("char not stored");
  a_ready_irq_gate: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !irq_en_r ##1 !irq_en_r |-> !RX_IRQ) else $error("irq without enable");
  a_irq_follows_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
      receive_ready_flag && irq_en_r |=> RX_IRQ) else $error("irq missing");
  a_ninth_in_filter: assert property (@(posedge CLOCK) disable iff (!RST_N)
      push && cfg.addr_detect_en |=> fifo_r[$past(wr_ptr_r)].data[8])
      else $error("ninth bit zero");
  a_inactive_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !rx_active |=> state_r == addr_rx_pkg::RX_IDLE) else $error("rx while off");
  a_overrun_cleared: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !cfg.continuous_receive_en |=> !overrun_r) else $error("overrun kept");
  a_overrun_sets: assert property (@(posedge CLOCK) disable iff (!RST_N)
      char_done && keep_char && count_r == 2'h2 && !rd_data_pop
      |=> overrun_r) else $error("overrun missed");
  a_overrun_blocks: assert property (@(posedge CLOCK) disable iff (!RST_N)
      overrun_r && !store |=> $stable(wr_ptr_r)) else $error("stored in overrun");
  a_fifo_depth_two: assert property (@(posedge CLOCK) disable iff (!RST_N)
      count_r <= 2'h2) else $error("fifo over depth");
  a_data_pops: assert property (@(posedge CLOCK) disable iff (!RST_N)
      rd_data_pop && count_r == 2'h1 && !store |=> count_r == 2'h0)
      else $error("pop lost");
  a_glitch_abort: assert property (@(posedge CLOCK) disable iff (!RST_N)
      state_r == addr_rx_pkg::RX_START && tick && tick_cnt_r == addr_rx_pkg::HALF_BIT_TICKS
      && RX_IN && rx_active && !overrun_r
      |=> state_r == addr_rx_pkg::RX_IDLE && !overrun_r) else $error("no abort");
  a_framing_stored: assert property (@(posedge CLOCK) disable iff (!RST_N)
      store && count_r == 2'h0 && !rd_data_pop
      |=> top.framing_error == $past(stop_bad)) else $error("framing lost");
  a_nine_bit_count: assert property (@(posedge CLOCK) disable iff (!RST_N)
      state_r == addr_rx_pkg::RX_STOP && rx_active
      |-> bit_cnt_r == data_bits) else $error("wrong bit count");
endmodule : addr_rx

// File: verilog/addr_rx_pkg.sv
package addr_rx_pkg;
  // APB byte addresses, one 32-bit word each
  localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RECEIVE_DATA = 8'h04;
  localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_RATE_DIVISOR_LOW = 8'h10;
  localparam logic [7:0] ADDR_RATE_DIVISOR_HIGH = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h1C;

  // receive_status_control fields
  localparam int SERIAL_PORT_EN_BIT = 7;
  localparam int NINE_BIT_RECEIVE_SEL_BIT = 6;
  localparam int CONTINUOUS_RECEIVE_EN_BIT = 4;
  localparam int ADDR_DETECT_EN_BIT = 3;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int NINTH_RECEIVE_BIT = 0;
  // transmit_status_control fields
  localparam int SYNC_MODE_BIT = 4;
  localparam int HIGH_SPEED_SEL_BIT = 2;
  localparam int SHIFT_EMPTY_BIT = 1;
  // baud_control fields
  localparam int RECEIVE_IDLE_BIT = 6;
  localparam int WIDE_DIVISOR_SEL_BIT = 3;

  localparam logic [7:0] RCV_CTRL_RESET = 8'h00;
  localparam logic [7:0] XMT_CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;

  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam int FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  typedef struct packed {
    logic framing_error;
    logic [8:0] data;
  } rx_char_t;

  typedef struct packed {
    logic serial_port_en;
    logic nine_bit_receive_sel;
    logic continuous_receive_en;
    logic addr_detect_en;
    logic sync_mode;
    logic high_speed_sel;
    logic wide_divisor_sel;
  } rx_cfg_t;
endpackage : addr_rx_pkg
